// ==== hw/rts_pkg.sv ====
// Constants, register map and carrier types of the reset timeout sequencer.
// Assumes a single 100 MHz APB clock domain.
`default_nettype none

package rts_pkg;

    // Clock rate and documented times
    localparam int unsigned CLK_MHZ             = 100;
    localparam int unsigned POWER_UP_DELAY_US   = 72000;
    localparam int unsigned BROWNOUT_MIN_US     = 100;
    localparam int unsigned POWER_UP_DELAY_CYC  = POWER_UP_DELAY_US * CLK_MHZ;
    localparam int unsigned BROWNOUT_MIN_CYC    = BROWNOUT_MIN_US * CLK_MHZ;
    localparam int unsigned OSC_STARTUP_EDGES   = 1024;
    localparam logic [10:0] OSC_LAST            = 11'(OSC_STARTUP_EDGES - 1);
    localparam logic [2:0]  PIN_FILTER_LAST     = 3'h3;

    // Register byte addresses
    localparam logic [7:0]  ADDR_FLAGS          = 8'h00;
    localparam logic [7:0]  ADDR_CFG            = 8'h04;
    localparam logic [7:0]  ADDR_STATE          = 8'h08;

    // Oscillator modes
    localparam logic [1:0]  OSC_LOW_POWER       = 2'h0;
    localparam logic [1:0]  OSC_CRYSTAL_MED     = 2'h1;
    localparam logic [1:0]  OSC_HIGH_SPEED      = 2'h2;
    localparam logic [1:0]  OSC_RESISTOR_CAP    = 2'h3;

    // Program counter load selection
    localparam logic [1:0]  PC_ZERO             = 2'h0;
    localparam logic [1:0]  PC_NEXT             = 2'h1;
    localparam logic [1:0]  PC_VECTOR           = 2'h2;

    typedef enum logic [2:0] {
        ST_BROWNOUT,
        ST_DELAY,
        ST_OSC,
        ST_PIN,
        ST_RUN
    } rts_state_t;

    // Flags register: bit0 brown-out, bit1 power-on, bit2 watchdog, bit3 sleep
    typedef struct packed {
        logic sleep_entered_flag_n;
        logic watchdog_expired_flag_n;
        logic por_flag_n;
        logic brownout_flag_n;
    } rts_flags_t;

    // Config register: bits 1:0 mode, bit2 delay enable (low), bit3 brown-out
    typedef struct packed {
        logic       brownout_detect_cfg;
        logic       power_up_delay_cfg_n;
        logic [1:0] osc_mode;
    } rts_cfg_t;

    localparam rts_flags_t FLAGS_RESET = 4'hF;
    localparam rts_cfg_t   CFG_RESET   = 4'h9;

endpackage : rts_pkg

`default_nettype wire

// ==== hw/rts_sequencer.sv ====
// Reset cause tracking and start-up time-out sequencing.
// Assumes pins arrive asynchronously, watchdog and sleep signals come from pclk logic.
`default_nettype none

module rts_sequencer
    import rts_pkg::*;
#(
    parameter int unsigned POWER_UP_CYCLES = POWER_UP_DELAY_CYC,
    parameter int unsigned BROWNOUT_CYCLES = BROWNOUT_MIN_CYC
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        supply_rise_detect,
    input  wire logic        supply_low_detect,
    input  wire logic        external_reset_pin_n,
    output logic             external_reset_pin_out,
    output logic             external_reset_pin_oe,
    input  wire logic        oscillator_input_pin,
    input  wire logic        watchdog_timeout,
    input  wire logic        core_sleeping,
    input  wire logic        sleep_enter,
    input  wire logic        wake_interrupt,
    input  wire logic        global_irq_enable,
    output var  logic        core_hold,
    output var  logic        regs_load_default,
    output var  logic [1:0]  pc_select,
    output var  logic        wake_resume
);

    // Pin synchronisers: bit0 rise, bit1 low supply, bit2 reset pin, bit3 oscillator
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic        por_d;
    logic        osc_d;
    rts_state_t  state;
    rts_state_t  next_state;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [10:0] osc_cnt;
    logic [10:0] next_osc_cnt;
    logic [31:0] dip_cnt;
    logic [2:0]  pin_cnt;
    logic        pin_low_f;
    logic        with_osc_count;
    logic        next_with_osc_count;
    rts_flags_t  flags;
    rts_flags_t  next_flags;
    rts_cfg_t    cfg;
    logic        next_load;
    logic [1:0]  next_pc;
    logic        next_wake;
    logic [31:0] next_prdata;

    wire logic por_rise   = sync2[0] & ~por_d;
    wire logic low_sup    = sync2[1];
    wire logic pin_s      = sync2[2];
    wire logic osc_edge   = sync2[3] & ~osc_d;
    wire logic dip_en     = cfg.brownout_detect_cfg;
    wire logic crystal    = (cfg.osc_mode != OSC_RESISTOR_CAP);
    wire logic delay_on   = ~cfg.power_up_delay_cfg_n | dip_en;
    wire logic dip_trip   = dip_en & low_sup & (dip_cnt == BROWNOUT_CYCLES);
    wire logic delay_done = (cnt == POWER_UP_CYCLES - 1);
    wire logic osc_done   = osc_edge & (osc_cnt == OSC_LAST);
    wire logic overrule   = por_rise | dip_trip;

    wire logic acc        = psel & penable;
    wire logic hit_flags  = (paddr == ADDR_FLAGS);
    wire logic hit_cfg    = (paddr == ADDR_CFG);
    wire logic hit_state  = (paddr == ADDR_STATE);
    wire logic hit_any    = hit_flags | hit_cfg | hit_state;
    wire logic wr_flags   = acc & pwrite & hit_flags;
    wire logic wr_cfg     = acc & pwrite & hit_cfg;

    // Zero-wait slave; error only on unmapped addresses
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;

    // Reset pin is input only, so watchdog resets stay internal
    assign external_reset_pin_out = 1'b0;
    assign external_reset_pin_oe  = 1'b0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 4'h4; // Pin idles high, so no false low after reset
            sync2 <= 4'h4;
            por_d <= 1'b0;
            osc_d <= 1'b0;
        end
        else
        begin
            sync1 <= {oscillator_input_pin, external_reset_pin_n,
                      supply_low_detect, supply_rise_detect};
            sync2 <= sync1;
            por_d <= sync2[0];
            osc_d <= sync2[3];
        end
    end

    // Consecutive-low counters; a high pin ends the filtered low at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_cnt   <= 3'h0;
            pin_low_f <= 1'b0;
            dip_cnt   <= 32'h0;
        end
        else
        begin
            pin_cnt   <= pin_s ? 3'h0 : (pin_cnt == PIN_FILTER_LAST ? pin_cnt : pin_cnt + 3'h1);
            pin_low_f <= ~pin_s & (pin_cnt == PIN_FILTER_LAST);
            dip_cnt   <= (dip_en & low_sup) ?
                         (dip_cnt == BROWNOUT_CYCLES ? dip_cnt : dip_cnt + 32'h1) : 32'h0;
        end
    end

    always_comb
    begin
        next_state    = state;
        next_cnt      = 32'h0;
        next_osc_cnt  = osc_cnt;
        next_with_osc_count = with_osc_count;
        next_flags    = flags;
        next_load     = regs_load_default;
        next_pc       = pc_select;
        next_wake     = 1'b0;
        // Software writes the brown-out and power-on flags; hardware clears below override it
        if (wr_flags)
        begin
            next_flags.brownout_flag_n = pwdata[0];
            next_flags.por_flag_n = pwdata[1];
        end
        if (por_rise)
        begin
            // Power-on pulse restarts the sequence; the brown-out flag and config are kept
            next_flags.por_flag_n              = 1'b0;
            next_flags.watchdog_expired_flag_n = 1'b1;
            next_flags.sleep_entered_flag_n    = 1'b1;
            next_load     = 1'b1;
            next_pc       = PC_ZERO;
            next_with_osc_count = crystal;
            next_osc_cnt  = 11'h0;
            next_state    = delay_on ? ST_DELAY : (crystal ? ST_OSC : ST_PIN);
        end
        else if (dip_trip && state != ST_BROWNOUT)
        begin
            // Brown-out flag only meaningful while detection is on
            next_flags.brownout_flag_n         = 1'b0;
            next_flags.watchdog_expired_flag_n = 1'b1;
            next_flags.sleep_entered_flag_n    = 1'b1;
            next_load     = 1'b1;
            next_pc       = PC_ZERO;
            next_with_osc_count = 1'b0;
            next_state    = ST_BROWNOUT;
        end
        else
        begin
            case (state)
                ST_BROWNOUT:
                begin
                    if (!low_sup)
                        next_state = ST_DELAY;
                end
                ST_DELAY:
                begin
                    next_cnt = cnt + 32'h1;
                    if (delay_done)
                    begin
                        next_cnt     = 32'h0;
                        next_osc_cnt = 11'h0;
                        next_state   = (with_osc_count && crystal) ? ST_OSC : ST_PIN;
                    end
                end
                ST_OSC:
                begin
                    if (osc_edge)
                        next_osc_cnt = osc_cnt + 11'h1;
                    if (osc_done)
                        next_state = ST_PIN;
                end
                ST_PIN:
                begin
                    // Synchronised release of several parts by the pin
                    if (!pin_low_f)
                        next_state = ST_RUN;
                end
                ST_RUN:
                begin
                    next_load = 1'b0;
                    if (pin_low_f)
                    begin
                        if (core_sleeping)
                        begin
                            next_flags.watchdog_expired_flag_n = 1'b1;
                            next_flags.sleep_entered_flag_n    = 1'b0;
                        end
                        next_load  = 1'b1;
                        next_pc    = PC_ZERO;
                        next_state = ST_PIN;
                    end
                    else if (watchdog_timeout && core_sleeping)
                    begin
                        next_flags.watchdog_expired_flag_n = 1'b0;
                        next_flags.sleep_entered_flag_n    = 1'b0;
                        next_pc      = PC_NEXT;
                        next_osc_cnt = 11'h0;
                        next_wake    = ~crystal;
                        next_state   = crystal ? ST_OSC : ST_RUN;
                    end
                    else if (watchdog_timeout)
                    begin
                        next_flags.watchdog_expired_flag_n = 1'b0;
                        next_flags.sleep_entered_flag_n    = 1'b1;
                        next_load  = 1'b1;
                        next_pc    = PC_ZERO;
                        next_state = ST_PIN;
                    end
                    else if (wake_interrupt && core_sleeping)
                    begin
                        next_flags.watchdog_expired_flag_n = 1'b1;
                        next_flags.sleep_entered_flag_n    = 1'b0;
                        next_pc      = global_irq_enable ? PC_VECTOR : PC_NEXT;
                        next_osc_cnt = 11'h0;
                        next_wake    = ~crystal;
                        next_state   = crystal ? ST_OSC : ST_RUN;
                    end
                    else if (sleep_enter)
                    begin
                        next_flags.watchdog_expired_flag_n = 1'b1;
                        next_flags.sleep_entered_flag_n    = 1'b0;
                    end
                end
                default:
                begin
                    next_state = ST_PIN;
                end
            endcase
        end
    end

    // Hold is registered so the core always leaves reset on a pclk edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state     <= ST_DELAY;
            cnt       <= 32'h0;
            osc_cnt   <= 11'h0;
            with_osc_count <= 1'b1;
            flags     <= FLAGS_RESET;
            core_hold <= 1'b1;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            osc_cnt   <= next_osc_cnt;
            with_osc_count <= next_with_osc_count;
            flags     <= next_flags;
            core_hold <= (next_state != ST_RUN);
        end
    end

    // Default loading goes to reset-dependent registers only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            regs_load_default <= 1'b1;
            pc_select         <= PC_ZERO;
            wake_resume       <= 1'b0;
        end
        else
        begin
            regs_load_default <= next_load;
            pc_select         <= next_pc;
            wake_resume       <= next_wake | (state == ST_OSC && osc_done && !with_osc_count);
        end
    end

    // Read data captured in setup phase; config changes act immediately
    assign next_prdata = hit_flags ? {28'h0, flags} :
                         hit_cfg   ? {28'h0, cfg}   :
                         hit_state ? {29'h0, state} : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg    <= CFG_RESET;
            prdata <= 32'h0;
        end
        else
        begin
            if (wr_cfg)
                cfg <= pwdata[3:0];
            if (psel && !penable)
                prdata <= next_prdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_pin_never_driven;
        !external_reset_pin_oe && !external_reset_pin_out;
    endproperty
    a_pin_never_driven: assert property (p_pin_never_driven)
        else $error("reset pin driven");

    property p_filter_len;
        pin_low_f |-> !$past(pin_s) && !$past(pin_s, 2) && !$past(pin_s, 3);
    endproperty
    a_filter_len: assert property (p_filter_len)
        else $error("pin reset accepted short pulse");

    property p_por_flags;
        por_rise |=> !flags.por_flag_n && flags.watchdog_expired_flag_n
                     && flags.sleep_entered_flag_n && core_hold && regs_load_default;
    endproperty
    a_por_flags: assert property (p_por_flags)
        else $error("power-on flags wrong");

    property p_brownout_enter;
        (dip_trip && !por_rise) |=> state == ST_BROWNOUT && !flags.brownout_flag_n && core_hold;
    endproperty
    a_brownout_enter: assert property (p_brownout_enter)
        else $error("brown-out not entered");

    property p_delay_restart;
        (state == ST_DELAY && dip_trip && !por_rise) |=> state == ST_BROWNOUT ##1 cnt == 32'h0;
    endproperty
    a_delay_restart: assert property (p_delay_restart)
        else $error("delay not restarted by dip");

    property p_osc_count_end;
        (state == ST_OSC && osc_done && !overrule) |=> state == ST_PIN && osc_cnt == OSC_LAST + 11'h1;
    endproperty
    a_osc_count_end: assert property (p_osc_count_end)
        else $error("oscillator count end wrong");

    property p_pin_release;
        (state == ST_PIN && !pin_low_f && !overrule) |=> !core_hold && state == ST_RUN;
    endproperty
    a_pin_release: assert property (p_pin_release)
        else $error("release after pin high delayed");

    property p_watchdog_wake;
        (state == ST_RUN && !pin_low_f && watchdog_timeout && core_sleeping && !overrule)
            |=> !flags.watchdog_expired_flag_n && !flags.sleep_entered_flag_n
                && pc_select == PC_NEXT && !regs_load_default;
    endproperty
    a_watchdog_wake: assert property (p_watchdog_wake)
        else $error("watchdog wake handled as reset");

    property p_delay_holds;
        state == ST_DELAY |-> core_hold;
    endproperty
    a_delay_holds: assert property (p_delay_holds)
        else $error("core released during delay");

endmodule // rts_sequencer

`default_nettype wire

// ==== tb/rts_partner.sv ====
// Model of the supply detectors, reset pin and oscillator around the sequencer.
// Assumes the bench requests each event; the crystal runs only while osc_run is high.
`default_nettype none
module rts_partner (
    input  wire logic rise_req,
    input  wire logic low_req,
    input  wire logic pin_low_req,
    input  wire logic osc_run,
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      supply_rise_detect,
    output logic      supply_low_detect,
    output logic      external_reset_pin_n,
    output logic      oscillator_input_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    assign supply_rise_detect   = rise_req;
    assign supply_low_detect    = low_req;
    // Pull-up to supply unless held low, so the pin can outlast time-outs
    assign external_reset_pin_n = pin_oe ? pin_out : !pin_low_req;
    // Stopped crystal rests low; 74 ns period keeps edges below pclk/4
    initial
    begin
        oscillator_input_pin = 1'b0;
        forever
        begin
            #37;
            oscillator_input_pin = osc_run & !oscillator_input_pin;
        end
    end
endmodule // rts_partner
`default_nettype wire

// ==== tb/rts_sequencer_bench.sv ====
// Self-checking bench of the reset timeout sequencer.
// Assumes shortened delay and brown-out counts; the partner models the pins.
`default_nettype none
module rts_sequencer_bench
    import rts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PU_CYC = 500;
    localparam int unsigned BO_CYC = 20;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        rise, low, pin_low, osc_run, rise_d, low_d, pin_n, pin_out, pin_oe, osc;
    logic        wd, slp, slp_en, wake_irq, gie, hold, rld, wres;
    logic [1:0]  pcs;
    int          miscompares, total_checks;

    rts_partner partner_u (
        .rise_req(rise), .low_req(low), .pin_low_req(pin_low), .osc_run(osc_run),
        .pin_out(pin_out), .pin_oe(pin_oe), .supply_rise_detect(rise_d),
        .supply_low_detect(low_d), .external_reset_pin_n(pin_n), .oscillator_input_pin(osc)
    );
    rts_sequencer #(.POWER_UP_CYCLES(PU_CYC), .BROWNOUT_CYCLES(BO_CYC)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_rise_detect(rise_d), .supply_low_detect(low_d), .external_reset_pin_n(pin_n),
        .external_reset_pin_out(pin_out), .external_reset_pin_oe(pin_oe),
        .oscillator_input_pin(osc), .watchdog_timeout(wd), .core_sleeping(slp),
        .sleep_enter(slp_en), .wake_interrupt(wake_irq), .global_irq_enable(gie),
        .core_hold(hold), .regs_load_default(rld), .pc_select(pcs), .wake_resume(wres)
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t signal got %h want %h", $time, got, exp);
        end
    endtask

    // Holds every request field until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        total_checks++;
        if (r !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t reg %h got %h want %h", $time, a, r, exp);
        end
    endtask

    // Counts cycles until the core is let go; both bounds are checked
    task automatic wait_release(input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (hold !== 1'b0 && n < hi)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk_sig(32'(hold === 1'b0 && n >= lo), 32'h1);
    endtask

    task automatic pulse_wd;
        wd <= 1'b1;
        tick(1);
        wd <= 1'b0;
        #1;
    endtask

    task automatic pulse_irq;
        wake_irq <= 1'b1;
        tick(1);
        wake_irq <= 1'b0;
        #1;
    endtask

    task automatic fin(input string s);
        $display("test %s finished", s);
    endtask

    task automatic t_powerup;
        #1;
        chk_sig(32'(hold), 32'h1);
        chk_reg(ADDR_CFG, 32'h9);
        chk_reg(ADDR_STATE, 32'h1);
        osc_run <= 1'b1;
        wait_release(PU_CYC + 7400, 20000);
        chk_sig(32'(pcs), 32'(PC_ZERO));
        fin("powerup");
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        wr(ADDR_FLAGS, 32'h3);
        chk_reg(ADDR_FLAGS, 32'hF);
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk_sig({r[30:0], e}, 32'h1);
        wr(8'h0C, 32'h0);
        chk_reg(ADDR_CFG, 32'h9);
        fin("regs");
    endtask

    task automatic t_por;
        wr(ADDR_CFG, 32'h5);
        rise <= 1'b1;
        tick(4);
        rise <= 1'b0;
        tick(2);
        #1;
        chk_sig(32'({hold, rld}), 32'h3);
        wait_release(7400, 7700);
        chk_reg(ADDR_FLAGS, 32'hD);
        wr(ADDR_FLAGS, 32'h3);
        fin("por");
    endtask

    task automatic t_brownout;
        wr(ADDR_CFG, 32'hD);
        low <= 1'b1;
        tick(BO_CYC / 2);
        low <= 1'b0;
        tick(8);
        #1;
        chk_sig(32'(hold), 32'h0);
        tick(1);
        low <= 1'b1;
        tick(BO_CYC + 8);
        chk_reg(ADDR_STATE, 32'h0);
        low <= 1'b0;
        tick(PU_CYC / 2);
        low <= 1'b1;
        tick(BO_CYC + 8);
        low <= 1'b0;
        wait_release(PU_CYC, PU_CYC + 100);
        chk_reg(ADDR_FLAGS, 32'hE);
        wr(ADDR_FLAGS, 32'h3);
        wr(ADDR_CFG, 32'h9);
        fin("brownout");
    endtask

    task automatic t_pin;
        pin_low <= 1'b1;
        tick(2);
        pin_low <= 1'b0;
        tick(8);
        #1;
        chk_sig(32'(hold), 32'h0);
        tick(1);
        pin_low <= 1'b1;
        tick(40);
        #1;
        chk_sig(32'({hold, rld, pin_oe}), 32'h6);
        tick(1);
        pin_low <= 1'b0;
        wait_release(0, 8);
        chk_reg(ADDR_FLAGS, 32'hF);
        slp <= 1'b1;
        pin_low <= 1'b1;
        tick(40);
        pin_low <= 1'b0;
        wait_release(0, 8);
        chk_sig(32'(pcs), 32'(PC_ZERO));
        chk_reg(ADDR_FLAGS, 32'h7);
        slp <= 1'b0;
        fin("pin");
    endtask

    task automatic t_wake;
        int          n;
        logic [31:0] r;
        logic        e;
        pulse_wd();
        wait_release(0, 20);
        chk_reg(ADDR_FLAGS, 32'hB);
        wr(ADDR_CFG, 32'hB);
        slp <= 1'b1;
        pulse_wd();
        chk_sig({wres, pcs, hold, rld, pin_oe}, 32'h28);
        chk_reg(ADDR_FLAGS, 32'h3);
        slp_en <= 1'b1;
        tick(1);
        slp_en <= 1'b0;
        gie <= 1'b1;
        pulse_irq();
        chk_sig({wres, pcs}, 32'h6);
        tick(1);
        gie <= 1'b0;
        pulse_irq();
        chk_sig({wres, pcs}, 32'h5);
        chk_reg(ADDR_FLAGS, 32'h7);
        wr(ADDR_CFG, 32'h9);
        pulse_wd();
        chk_reg(ADDR_STATE, 32'h2);
        n = 0;
        do
        begin
            apb(1'b0, ADDR_STATE, 32'h0, r, e);
            n++;
        end
        while (r !== 32'h4 && n < 4000);
        chk_sig(32'(r === 32'h4 && n > 2000), 32'h1);
        slp <= 1'b0;
        fin("wake");
    endtask

    initial
    begin
        #1000000;
        miscompares++;
        $display("[ERR] %0t run did not finish", $time);
        test_done();
    end

    initial
    begin
        miscompares = 0;
        total_checks = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {rise, low, pin_low, osc_run, wd, slp, slp_en, wake_irq, gie} = '0;
        tick(8);
        presetn <= 1'b1;
        t_powerup();
        t_regs();
        t_por();
        t_brownout();
        t_pin();
        t_wake();
        test_done();
    end
endmodule // rts_sequencer_bench
`default_nettype wire
